// ===== core/dac_path_control_register.v
`timescale 1ns/1ps
`include "dac_path_defines.vh"
module dac_path_control_register (
    input wire i_ref_clk,
    input wire i_rst,
    input wire i_wr_en,
    input wire i_rd_en,
    input wire [7:0] i_addr,
    input wire [15:0] i_wr_data,
    input wire i_sample_valid,
    input wire i_sample_zero,
    input wire i_master_mute_state,
    input wire [2:0] i_first_channel_deemph,
    input wire [2:0] i_second_channel_deemph,
    input wire i_mix_gain_sel,
    output reg [15:0] o_rd_data,
    output reg o_rd_valid,
    output reg o_output_polarity_invert,
    output reg o_shaper_order_select,
    output reg o_mix_enable,
    output reg o_mix_after_processing,
    output reg [2:0] o_first_channel_source,
    output reg [2:0] o_second_channel_source,
    output reg [3:0] o_dac_gain_db,
    output reg [3:0] o_mix_gain_db,
    output reg [3:0] o_first_deemph_sel,
    output reg [3:0] o_second_deemph_sel,
    output reg o_quiet_detected,
    output reg o_converter_core_silence,
    output reg o_resonant_bass,
    output reg o_mix_bypass,
    output reg [1:0] o_input_rate_mode,
    output reg o_rate_reserved
);

// Control word, latched sources and detector state
reg [15:0] dac_path_control;
reg [1:0] first_src_code;
reg [1:0] second_src_code;
reg [14:0] zero_count;
reg [14:0] quiet_threshold;
// Decoder results ahead of the output flops
reg [2:0] next_first_src;
reg [2:0] next_second_src;
reg [3:0] next_first_de;
reg [3:0] next_second_de;

// Reset word as a constant so its fields can be sliced
localparam [15:0] CTRL_RESET = `DAC_PATH_CONTROL_RESET;

// Internal strobes and conditions
wire wr_hit;
wire mix_on;
wire quiet_detect_enable;
wire quiet_now;

// Only the single mapped address takes a write
assign wr_hit = i_wr_en && (i_addr == `DAC_PATH_CONTROL_ADDR);
assign mix_on = dac_path_control[`MIX_EN_BIT];
assign quiet_detect_enable = dac_path_control[`QDET_EN_BIT];
// Detector output is held low while the detector is off
assign quiet_now = quiet_detect_enable && (zero_count >= quiet_threshold);

// Source code to one-hot path select
function [2:0] src_decode;
    input [1:0] code;
    begin
        case (code)
            `SRC_ADC: src_decode = `SRC_HOT_ADC;
            // Codes 01 and 11 both pick the serial input
            `SRC_SERIAL: src_decode = `SRC_HOT_SERIAL;
            `SRC_IEC: src_decode = `SRC_HOT_IEC;
            `SRC_SERIAL_ALT: src_decode = `SRC_HOT_SERIAL;
            default: src_decode = `SRC_HOT_SERIAL;
        endcase
    end
endfunction

// De-emphasis code to one-hot filter select
function [3:0] de_decode;
    input [2:0] code;
    begin
        case (code)
            `DE_OFF: de_decode = `DE_HOT_OFF;
            `DE_32K: de_decode = `DE_HOT_32K;
            `DE_44K: de_decode = `DE_HOT_44K;
            `DE_48K: de_decode = `DE_HOT_48K;
            `DE_96K: de_decode = `DE_HOT_96K;
            default: de_decode = `DE_HOT_OFF;
        endcase
    end
endfunction

// Register write and read-back
always @(posedge i_ref_clk) begin
    if (i_rst) begin
        dac_path_control <= `DAC_PATH_CONTROL_RESET;
        o_rd_data <= 16'h0000;
        o_rd_valid <= 1'b0;
    end else begin
        // Writes to other addresses are dropped
        if (wr_hit) begin
            dac_path_control <= i_wr_data;
        end
        // Data is zero outside a mapped read so it can be OR-combined
        o_rd_valid <= i_rd_en;
        if (i_rd_en && (i_addr == `DAC_PATH_CONTROL_ADDR)) begin
            o_rd_data <= dac_path_control;
        end else begin
            o_rd_data <= 16'h0000; // Unmapped reads as zero
        end
    end
end

// Threshold lookup from the two-bit setting
always @* begin
    // Zero-sample threshold
    // Thresholds count samples, not clock cycles
    case (dac_path_control[`QTHR_HI:`QTHR_LO])
        2'h0: quiet_threshold = `QTHR_COUNT0;
        2'h1: quiet_threshold = `QTHR_COUNT1;
        2'h2: quiet_threshold = `QTHR_COUNT2;
        default: quiet_threshold = `QTHR_COUNT3;
    endcase
end

// Consecutive zero sample counter, saturating at the largest threshold
always @(posedge i_ref_clk) begin
    if (i_rst) begin
        zero_count <= 15'h0000;
    end else if (!quiet_detect_enable) begin
        zero_count <= 15'h0000;
    end else if (i_sample_valid) begin
        if (!i_sample_zero) begin
            // A non-zero sample restarts the run
            zero_count <= 15'h0000;
        end else if (zero_count < `QTHR_COUNT3) begin
            // Saturating keeps the count from wrapping below a threshold
            zero_count <= zero_count + 15'h0001;
        end
    end
end

// Latched source codes; a new code only lands while mixing is on
// Holding codes while mixing is off keeps the path from switching mid-stream
always @(posedge i_ref_clk) begin
    if (i_rst) begin
        first_src_code <= CTRL_RESET[`CH1_SRC_HI:`CH1_SRC_LO];
        second_src_code <= CTRL_RESET[`CH2_SRC_HI:`CH2_SRC_LO];
    end else if (mix_on) begin
        first_src_code <= dac_path_control[`CH1_SRC_HI:`CH1_SRC_LO];
        second_src_code <= dac_path_control[`CH2_SRC_HI:`CH2_SRC_LO];
    end
end

// Decode of sources and de-emphasis selections
// Decoders are combinational; the output flops add the cycle
always @* begin
    next_first_src = src_decode(first_src_code);
    next_second_src = src_decode(second_src_code);
    next_first_de = de_decode(i_first_channel_deemph);
    next_second_de = de_decode(i_second_channel_deemph);
end

// Polarity and noise shaper order
always @(posedge i_ref_clk) begin
    if (i_rst) begin
        o_output_polarity_invert <= CTRL_RESET[`POL_INV_BIT];
        o_shaper_order_select <= CTRL_RESET[`SHAPER_BIT];
    end else begin
        o_output_polarity_invert <= dac_path_control[`POL_INV_BIT];
        o_shaper_order_select <= dac_path_control[`SHAPER_BIT];
    end
end

// Mixer enable and position; position means nothing while mixing is off
always @(posedge i_ref_clk) begin
    if (i_rst) begin
        o_mix_enable <= CTRL_RESET[`MIX_EN_BIT];
        o_mix_after_processing <= 1'b0;
    end else begin
        o_mix_enable <= mix_on;
        o_mix_after_processing <= mix_on && dac_path_control[`MIX_POS_BIT];
    end
end

// One-hot channel sources from the latched codes
always @(posedge i_ref_clk) begin
    if (i_rst) begin
        o_first_channel_source <= `SRC_HOT_SERIAL;
        o_second_channel_source <= `SRC_HOT_SERIAL;
    end else begin
        o_first_channel_source <= next_first_src;
        o_second_channel_source <= next_second_src;
    end
end

// Gain pair; the converter path stays at unity in both mixer gain settings
always @(posedge i_ref_clk) begin
    if (i_rst) begin
        o_dac_gain_db <= `GAIN_0DB;
        o_mix_gain_db <= `GAIN_0DB;
    end else if (mix_on && !i_mix_gain_sel) begin
        o_dac_gain_db <= `GAIN_0DB;
        o_mix_gain_db <= `GAIN_M6DB;
    end else begin
        o_dac_gain_db <= `GAIN_0DB;
        o_mix_gain_db <= `GAIN_0DB;
    end
end

// De-emphasis selections, one cycle behind the codes
always @(posedge i_ref_clk) begin
    if (i_rst) begin
        o_first_deemph_sel <= `DE_HOT_OFF;
        o_second_deemph_sel <= `DE_HOT_OFF;
    end else begin
        o_first_deemph_sel <= next_first_de;
        o_second_deemph_sel <= next_second_de;
    end
end

// Silence flag and converter silence switch
always @(posedge i_ref_clk) begin
    if (i_rst) begin
        o_quiet_detected <= 1'b0;
        o_converter_core_silence <= 1'b0;
    end else begin
        // Flag mirrors the detector so software can see it
        o_quiet_detected <= quiet_now;
        if (dac_path_control[`SILENCE_BIT]) begin
            o_converter_core_silence <= 1'b1;
        end else begin
            o_converter_core_silence <= quiet_now || i_master_mute_state;
        end
    end
end

// Bass boost type and mixer bypass
always @(posedge i_ref_clk) begin
    if (i_rst) begin
        o_resonant_bass <= CTRL_RESET[`BASS_SEL_BIT];
        o_mix_bypass <= CTRL_RESET[`BYPASS_BIT];
    end else begin
        o_resonant_bass <= dac_path_control[`BASS_SEL_BIT];
        o_mix_bypass <= dac_path_control[`BYPASS_BIT];
    end
end

// Input rate mode with a flag for the reserved code
always @(posedge i_ref_clk) begin
    if (i_rst) begin
        o_input_rate_mode <= CTRL_RESET[`RATE_HI:`RATE_LO];
        o_rate_reserved <= 1'b0;
    end else begin
        o_input_rate_mode <= dac_path_control[`RATE_HI:`RATE_LO];
        // Reserved code passes through; the flag lets users catch it
        o_rate_reserved <= &dac_path_control[`RATE_HI:`RATE_LO];
    end
end

endmodule // dac_path_control_register

// ===== inc/dac_path_defines.vh
`ifndef DAC_PATH_DEFINES_VH
`define DAC_PATH_DEFINES_VH

// Register address of the control word
`define DAC_PATH_CONTROL_ADDR 8'h14
// Reset value: bits 14, 11, 10 and 8 set
`define DAC_PATH_CONTROL_RESET 16'h4d00

// Field positions
`define POL_INV_BIT 15
`define SHAPER_BIT 14
`define MIX_POS_BIT 13
`define MIX_EN_BIT 12
`define CH2_SRC_HI 11
`define CH2_SRC_LO 10
`define CH1_SRC_HI 9
`define CH1_SRC_LO 8
`define SILENCE_BIT 7
`define QDET_EN_BIT 6
`define QTHR_HI 5
`define QTHR_LO 4
`define BASS_SEL_BIT 3
`define BYPASS_BIT 2
`define RATE_HI 1
`define RATE_LO 0

// Zero-sample thresholds of the silence detector
`define QTHR_COUNT0 15'd3200
`define QTHR_COUNT1 15'd4800
`define QTHR_COUNT2 15'd9600
`define QTHR_COUNT3 15'd19200

// Source codes
`define SRC_ADC 2'h0
`define SRC_SERIAL 2'h1
`define SRC_IEC 2'h2
`define SRC_SERIAL_ALT 2'h3

// Source one-hot outputs: bit0 ADC, bit1 serial, bit2 IEC
`define SRC_HOT_ADC 3'h1
`define SRC_HOT_SERIAL 3'h2
`define SRC_HOT_IEC 3'h4

// De-emphasis one-hot: bit0 32k, bit1 44.1k, bit2 48k, bit3 96k, 0 = off
`define DE_OFF 3'h0
`define DE_32K 3'h1
`define DE_44K 3'h2
`define DE_48K 3'h3
`define DE_96K 3'h4
`define DE_HOT_OFF 4'h0
`define DE_HOT_32K 4'h1
`define DE_HOT_44K 4'h2
`define DE_HOT_48K 4'h4
`define DE_HOT_96K 4'h8

// Gains in 0.5 dB-free plain dB, signed 4 bits
`define GAIN_0DB 4'h0
`define GAIN_M6DB 4'ha

// Input rate modes
`define RATE_SINGLE 2'h0
`define RATE_DOUBLE 2'h1
`define RATE_QUAD 2'h2

`endif

// ===== verification/dac_path_control_register_sva.sv
`timescale 1ns/1ps
module dac_path_sva (
    input wire i_ref_clk,
    input wire i_rst,
    input wire i_rd_en,
    input wire [7:0] i_addr,
    input wire i_master_mute_state,
    input wire [2:0] i_first_channel_deemph,
    input wire i_mix_gain_sel,
    input wire [15:0] o_rd_data,
    input wire o_rd_valid,
    input wire o_mix_enable,
    input wire o_mix_after_processing,
    input wire [3:0] o_mix_gain_db,
    input wire [3:0] o_first_deemph_sel,
    input wire o_converter_core_silence,
    input wire [1:0] o_input_rate_mode,
    input wire o_rate_reserved
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    // One-hot select for a de-emphasis code
    function automatic [3:0] dh(input [2:0] c);
        dh = (c == 3'h0 || c > 3'h4) ? 4'h0 : 4'h1 << (c - 3'h1);
    endfunction
    chk_read_answered: assert property (i_rd_en |=> o_rd_valid)
        else $error("read not answered");
    chk_unmapped_zero: assert property
        (i_rd_en && i_addr != 8'h14 |=> o_rd_data == 16'h0)
        else $error("unmapped read not zero");
    chk_mix_gain_low: assert property
        (o_mix_enable && !$past(i_mix_gain_sel) && !$past(i_rst)
         |-> o_mix_gain_db == 4'ha) else $error("mixer gain not -6");
    chk_mix_gain_flat: assert property
        ((!o_mix_enable || $past(i_mix_gain_sel)) && !$past(i_rst)
         |-> o_mix_gain_db == 4'h0) else $error("mixer gain not 0");
    chk_mute_silences: assert property
        ($past(i_master_mute_state) && !$past(i_rst)
         |-> o_converter_core_silence) else $error("mute not silent");
    chk_deemph_decode: assert property
        (!$past(i_rst) |-> o_first_deemph_sel ==
         dh($past(i_first_channel_deemph))) else $error("bad deemph");
    chk_rate_reserved: assert property
        (o_rate_reserved == (o_input_rate_mode == 2'h3))
        else $error("reserved flag wrong");
    chk_mix_pos_gated: assert property
        (o_mix_after_processing |-> o_mix_enable)
        else $error("position without mixer");
    // Main scenarios reached
    cover property (o_mix_gain_db == 4'ha);
    cover property (o_rate_reserved);
    cover property (o_converter_core_silence && !i_master_mute_state);
endmodule // dac_path_sva

bind dac_path_control_register dac_path_sva u_sva (
    .i_ref_clk, .i_rst, .i_rd_en, .i_addr, .i_master_mute_state,
    .i_first_channel_deemph, .i_mix_gain_sel, .o_rd_data, .o_rd_valid,
    .o_mix_enable, .o_mix_after_processing, .o_mix_gain_db,
    .o_first_deemph_sel, .o_converter_core_silence, .o_input_rate_mode,
    .o_rate_reserved
);

// ===== verification/tb_dac_path_control_register.sv
`timescale 1ns/1ps
module tb_dac_path_control_register;
    logic i_ref_clk = 1'b0, i_rst = 1'b1, i_wr_en = 1'b0, i_rd_en = 1'b0;
    logic i_sample_valid = 1'b0, i_sample_zero = 1'b0;
    logic i_master_mute_state = 1'b0, i_mix_gain_sel = 1'b0;
    logic [7:0] i_addr = 8'h14;
    logic [15:0] i_wr_data = 16'h0;
    logic [2:0] i_first_channel_deemph = 3'h0;
    logic [2:0] i_second_channel_deemph = 3'h0;
    wire [15:0] o_rd_data;
    wire o_rd_valid, o_output_polarity_invert, o_shaper_order_select;
    wire o_mix_enable, o_mix_after_processing, o_quiet_detected;
    wire o_converter_core_silence, o_resonant_bass, o_mix_bypass;
    wire o_rate_reserved;
    wire [1:0] o_input_rate_mode;
    wire [2:0] o_first_channel_source, o_second_channel_source;
    wire [3:0] o_dac_gain_db, o_mix_gain_db;
    wire [3:0] o_first_deemph_sel, o_second_deemph_sel;
    int miscompares = 0, cmp_count = 0, i, t;
    int thr[4] = '{3200, 4800, 9600, 19200};
    dac_path_control_register dut (
        .i_ref_clk, .i_rst, .i_wr_en, .i_rd_en, .i_addr, .i_wr_data,
        .i_sample_valid, .i_sample_zero, .i_master_mute_state,
        .i_first_channel_deemph, .i_second_channel_deemph, .i_mix_gain_sel,
        .o_rd_data, .o_rd_valid, .o_output_polarity_invert,
        .o_shaper_order_select, .o_mix_enable, .o_mix_after_processing,
        .o_first_channel_source, .o_second_channel_source, .o_dac_gain_db,
        .o_mix_gain_db, .o_first_deemph_sel, .o_second_deemph_sel,
        .o_quiet_detected, .o_converter_core_silence, .o_resonant_bass,
        .o_mix_bypass, .o_input_rate_mode, .o_rate_reserved
    );
    // Free-running reference clock
    always #50 i_ref_clk = ~i_ref_clk;
    // Expected de-emphasis select
    function automatic [3:0] dh(input int c);
        dh = (c >= 1 && c <= 4) ? 4'h1 << (c - 1) : 4'h0;
    endfunction
    task tick(input int n);
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask
    task ck(input string s, input [15:0] e, input [15:0] g);
        cmp_count++;
        if (e !== g) begin
            miscompares++;
            $display("[FAIL] %s exp %h got %h", s, e, g);
        end
    endtask
    task wr(input [15:0] d);
        i_wr_data = d;
        i_wr_en = 1'b1;
        tick(1);
        i_wr_en = 1'b0;
        tick(2);
    endtask
    task rd(input [15:0] e);
        i_rd_en = 1'b1;
        tick(1);
        i_rd_en = 1'b0;
        ck("valid", 16'h1, {15'h0, o_rd_valid});
        ck("rdata", e, o_rd_data);
        tick(1);
    endtask
    task feed(input int n, input logic z);
        i_sample_valid = 1'b1;
        i_sample_zero = z;
        tick(n);
        i_sample_valid = 1'b0;
        tick(2);
    endtask
    task summarize;
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Main sequence
    initial begin
        tick(4);
        i_rst = 1'b0;
        tick(2);
        rd(16'h4d00); // reset word
        ck("shp", 1, o_shaper_order_select); // reset
        ck("src2", 3'h2, o_second_channel_source); // reset
        wr(16'h8000); // invert, third order
        ck("pol", 1, o_output_polarity_invert); // set
        ck("shp", 0, o_shaper_order_select); // third
        wr(16'h300e); // mixer on, after
        ck("mix", 1, o_mix_enable); // on
        ck("pos", 1, o_mix_after_processing); // after
        ck("bass", 1, o_resonant_bass); // resonant
        ck("byp", 1, o_mix_bypass); // bypass
        ck("rate", 2'h2, o_input_rate_mode); // quad
        ck("rsv", 0, o_rate_reserved); // code 10
        ck("src1", 3'h1, o_first_channel_source); // ADC
        ck("src2", 3'h1, o_second_channel_source); // ADC
        rd(16'h300e); // readback
        wr(16'h0a03); // mixer off
        ck("src1", 3'h1, o_first_channel_source); // held
        ck("rsv", 1, o_rate_reserved); // code 11
        ck("rate", 2'h3, o_input_rate_mode); // code 11
        ck("mix", 0, o_mix_enable); // off
        ck("pos", 0, o_mix_after_processing); // position bit clear
        ck("mixg", 4'h0, o_mix_gain_db); // mixer off
        ck("bass", 0, o_resonant_bass); // normal
        ck("byp", 0, o_mix_bypass); // mixer mode
        ck("pol", 0, o_output_polarity_invert); // clear
        wr(16'h1a00); // mixer on, IEC
        ck("src1", 3'h4, o_first_channel_source); // IEC
        ck("src2", 3'h4, o_second_channel_source); // IEC
        ck("pos", 0, o_mix_after_processing); // before
        i_addr = 8'h15;
        wr(16'hffff); // unmapped
        rd(16'h0); // unmapped
        i_addr = 8'h14;
        rd(16'h1a00); // unchanged
        $display("test register fields done");
        tick(2);
        ck("mixg", 4'ha, o_mix_gain_db); // minus six
        ck("dacg", 4'h0, o_dac_gain_db); // zero
        i_mix_gain_sel = 1'b1;
        tick(2);
        ck("mixg", 4'h0, o_mix_gain_db); // flat
        for (i = 0; i < 8; i++) begin
            i_first_channel_deemph = i[2:0];
            i_second_channel_deemph = 3'h7 - i[2:0];
            tick(2);
            ck("de1", dh(i), o_first_deemph_sel);
            ck("de2", dh(7 - i), o_second_deemph_sel);
        end
        $display("test gain and deemph done");
        wr(16'h0000); // detector off
        i_master_mute_state = 1'b1;
        tick(2);
        ck("sil", 1, o_converter_core_silence); // muted
        i_master_mute_state = 1'b0;
        tick(2);
        ck("sil", 0, o_converter_core_silence); // quiet off
        wr(16'h0080); // override
        ck("sil", 1, o_converter_core_silence); // forced
        feed(3300, 1'b1); // detector off
        ck("qd", 0, o_quiet_detected); // disabled
        wr(16'h0000); // override off
        for (t = 0; t < 4; t++) begin
            wr({10'h001, t[1:0], 4'h0}); // enable, threshold
            feed(thr[t] - 1, 1'b1); // one short
            ck("qd", 0, o_quiet_detected); // short
            feed(1, 1'b1); // threshold reached
            ck("qd", 1, o_quiet_detected); // reached
            ck("sil", 1, o_converter_core_silence); // detector
            feed(1, 1'b0); // non-zero sample
            ck("qd", 0, o_quiet_detected); // cleared
            ck("sil", 0, o_converter_core_silence); // follows
            wr(16'h0000); // detector off
        end
        $display("test silence done");
        summarize;
    end
    // Watchdog against a hang
    initial begin
        #6000000;
        miscompares++;
        summarize;
    end
endmodule // tb_dac_path_control_register
